// ==== hw/pss_params.svh ====
// Register offsets, bit positions and reset values of the status summary block
`ifndef PSS_PARAMS_SVH
`define PSS_PARAMS_SVH

// ---------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------------------
`define PSS_IDX_BASIC_STAT  6'h01
`define PSS_IDX_AN_EXPAND   6'h06
`define PSS_IDX_SUMMARY     6'h10
`define PSS_IDX_ISER        6'h12
`define PSS_IDX_FCCR        6'h14
`define PSS_IDX_RXERR_CNT   6'h15
`define PSS_IDX_TENMEG      6'h1A
`define PSS_IDX_IRQ_STATUS  6'h20
`define PSS_IDX_IRQ_MASK    6'h21
`define PSS_IDX_XOVER_CTRL  6'h22

// ---------------------------------------------------------------------------
// Summary word bit positions
// ---------------------------------------------------------------------------
`define PSS_BIT_RSVD        15
`define PSS_BIT_XOVER       14
`define PSS_BIT_RXERR       13
`define PSS_BIT_POL         12
`define PSS_BIT_FCAR        11
`define PSS_BIT_SIGDET      10
`define PSS_BIT_LOCK        9
`define PSS_BIT_PAGE        8
`define PSS_BIT_IRQ         7
`define PSS_BIT_RFAULT      6

// Crossover control bits
`define PSS_XC_ENABLE       0
`define PSS_XC_FORCE        1

// Interrupt status bit positions
`define PSS_EV_RXERR        0
`define PSS_EV_FCAR         1
`define PSS_EV_RFAULT       2

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define PSS_RST_WORD        32'h0000_0000
`define PSS_RST_EV          3'h0
`define PSS_RST_XC          2'h1
`define PSS_EV_W            3
`define PSS_XC_W            2

`endif

// ==== hw/pss_pkg.sv ====
// Types shared by the status summary block
package pss_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pss_apb_req_type;

  typedef struct packed {
    logic        auto_swapped;
    logic        rx_error;
    logic        polarity_inverted;
    logic        false_carrier;
    logic        signal_detect;
    logic        descrambler_lock;
    logic        page_received;
    logic        irq_pending;
    logic        partner_remote_fault;
  } pss_phy_in_type;

  typedef enum logic [1:0] {
    PSS_IDLE,
    PSS_ACCESS
  } pss_bus_state_type;

endpackage : pss_pkg

// ==== hw/pss_status_summary.sv ====
// Summary status register with its source-register read side effects
//
// Overview of operation
// - Top bit always reads zero; writes to it are discarded.
// - Crossover bit reads 1 when pairs are swapped, 0 when normal.
// - Crossover bit follows enable/force; tracks auto swap when enabled, unforced.
// - Receive-error latch sets on any receive error, holds until counter read.
// - Reading receive error counter clears latch; summary read does not.
// - Polarity bit mirrors inverted polarity flag of ten-meg register.
// - Polarity bit clears on ten-meg register read, not on summary read.
// - False-carrier latch sets on event, cleared by false carrier counter read.
// - Signal detect bit latches low once the signal drops.
// - Descrambler lock bit latches low once lock is lost.
// - Page-received bit copies expansion flag, cleared only by that read.
// - Interrupt-pending bit shows pending interrupt; event register read clears.
// - Remote-fault bit sets on fault, cleared by basic status read or reset.
// - Remote fault detected only from partner notification in negotiation.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "pss_params.svh"

module pss_status_summary
  import pss_pkg::*;
(
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           reset_n,
  // APB slave
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [11:0]    paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  // Status sources from the transceiver core (asynchronous)
  input  wire pss_phy_in_type phy_in,
  // Interrupt
  output logic                irq
);

  // -------------------------------------------------------------------------
  // Input synchronisers
  // -------------------------------------------------------------------------
  pss_phy_in_type sync_a;
  pss_phy_in_type sync_b;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= phy_in;
      sync_b <= sync_a;
    end
  end

  // -------------------------------------------------------------------------
  // APB decode
  // -------------------------------------------------------------------------
  pss_bus_state_type state;
  wire               setup     = psel && !penable;
  wire               access_ok = (state == PSS_ACCESS) && psel && penable;
  wire [5:0]         idx       = paddr[7:2];
  wire               in_range  = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'h0);
  wire               rd        = setup && !pwrite && in_range;
  // Writes land at the access edge, where the master sees pready
  wire               wr        = access_ok && pwrite && in_range;

  wire rd_basic  = rd && (idx == `PSS_IDX_BASIC_STAT);
  wire rd_expand = rd && (idx == `PSS_IDX_AN_EXPAND);
  wire rd_iser   = rd && (idx == `PSS_IDX_ISER);
  wire rd_fccr   = rd && (idx == `PSS_IDX_FCCR);
  wire rd_rxcnt  = rd && (idx == `PSS_IDX_RXERR_CNT);
  wire rd_tenmeg = rd && (idx == `PSS_IDX_TENMEG);
  wire wr_istat  = wr && (idx == `PSS_IDX_IRQ_STATUS);
  wire wr_imask  = wr && (idx == `PSS_IDX_IRQ_MASK);
  wire wr_xc     = wr && (idx == `PSS_IDX_XOVER_CTRL);

  wire mapped = (idx == `PSS_IDX_BASIC_STAT) || (idx == `PSS_IDX_AN_EXPAND)
             || (idx == `PSS_IDX_SUMMARY) || (idx == `PSS_IDX_ISER)
             || (idx == `PSS_IDX_FCCR) || (idx == `PSS_IDX_RXERR_CNT)
             || (idx == `PSS_IDX_TENMEG) || (idx == `PSS_IDX_IRQ_STATUS)
             || (idx == `PSS_IDX_IRQ_MASK) || (idx == `PSS_IDX_XOVER_CTRL);
  wire bad   = setup && !(in_range && mapped);

  // -------------------------------------------------------------------------
  // Status latches
  // -------------------------------------------------------------------------
  logic [`PSS_XC_W-1:0] xover_ctrl;
  logic                 rxerr_latch;
  logic                 fcar_latch;
  logic                 pol_flag;
  logic                 page_flag;
  logic                 irq_flag;
  logic                 rfault_flag;
  logic                 sigdet_ll;
  logic                 lock_ll;

  // Crossover: forced swap wins, else auto when enabled, else normal
  wire xover_now = xover_ctrl[`PSS_XC_FORCE] ? 1'b1
                 : (xover_ctrl[`PSS_XC_ENABLE] ? sync_b.auto_swapped
                 : 1'b0);

  // Set wins over clear in every latch
  wire next_rxerr  = sync_b.rx_error || (rxerr_latch && !rd_rxcnt);
  wire next_fcar   = sync_b.false_carrier
                   || (fcar_latch && !rd_fccr);
  wire next_pol    = sync_b.polarity_inverted
                   || (pol_flag && !rd_tenmeg);
  wire next_page   = sync_b.page_received
                   || (page_flag && !rd_expand);
  wire next_irq    = sync_b.irq_pending || (irq_flag && !rd_iser);
  wire next_rfault = sync_b.partner_remote_fault
                   || (rfault_flag && !rd_basic);
  // Latch low: a drop holds 0 until a summary read re-samples the live level
  wire rd_summary  = rd && (idx == `PSS_IDX_SUMMARY);
  wire next_sigdet = rd_summary ? sync_b.signal_detect
                   : (sigdet_ll && sync_b.signal_detect);
  wire next_lock   = rd_summary ? sync_b.descrambler_lock
                   : (lock_ll && sync_b.descrambler_lock);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rxerr_latch <= 1'b0;
      fcar_latch  <= 1'b0;
      pol_flag    <= 1'b0;
      page_flag   <= 1'b0;
      irq_flag    <= 1'b0;
      rfault_flag <= 1'b0;
      sigdet_ll   <= 1'b0;
      lock_ll     <= 1'b0;
    end else begin
      rxerr_latch <= next_rxerr;
      fcar_latch  <= next_fcar;
      pol_flag    <= next_pol;
      page_flag   <= next_page;
      irq_flag    <= next_irq;
      rfault_flag <= next_rfault;
      sigdet_ll   <= next_sigdet;
      lock_ll     <= next_lock;
    end
  end

  // Summary word; bits 5..0 live elsewhere and read as zero here
  logic [15:0] summary;
  always_comb begin
    summary                = 16'h0000;
    summary[`PSS_BIT_RSVD]   = 1'b0;
    summary[`PSS_BIT_XOVER]  = xover_now;
    summary[`PSS_BIT_RXERR]  = rxerr_latch;
    summary[`PSS_BIT_POL]    = pol_flag;
    summary[`PSS_BIT_FCAR]   = fcar_latch;
    summary[`PSS_BIT_SIGDET] = sigdet_ll;
    summary[`PSS_BIT_LOCK]   = lock_ll;
    summary[`PSS_BIT_PAGE]   = page_flag;
    summary[`PSS_BIT_IRQ]    = irq_flag;
    summary[`PSS_BIT_RFAULT] = rfault_flag;
  end

  // -------------------------------------------------------------------------
  // Interrupt status and mask
  // -------------------------------------------------------------------------
  logic [`PSS_EV_W-1:0] irq_status;
  logic [`PSS_EV_W-1:0] irq_mask;
  logic [`PSS_EV_W-1:0] events;
  always_comb begin
    events                = `PSS_RST_EV;
    events[`PSS_EV_RXERR]  = sync_b.rx_error;
    events[`PSS_EV_FCAR]   = sync_b.false_carrier;
    events[`PSS_EV_RFAULT] = sync_b.partner_remote_fault;
  end
  wire [`PSS_EV_W-1:0] w1c = wr_istat ? pwdata[`PSS_EV_W-1:0] : `PSS_RST_EV;
  wire [`PSS_EV_W-1:0] next_istat = events | (irq_status & ~w1c);
  // Use the mask as it is being written, so irq never lags a mask update
  wire [`PSS_EV_W-1:0] next_mask = wr_imask ? pwdata[`PSS_EV_W-1:0] : irq_mask;
  wire                 next_irq_out = |(next_istat & next_mask);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_status <= `PSS_RST_EV;
      irq_mask   <= `PSS_RST_EV;
      xover_ctrl <= `PSS_RST_XC;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_istat;
      irq        <= next_irq_out;
      irq_mask   <= next_mask;
      if (wr_xc)
        xover_ctrl <= pwdata[`PSS_XC_W-1:0];
    end
  end

  // -------------------------------------------------------------------------
  // Read mux and bus response (no wait states: answer at first access edge)
  // -------------------------------------------------------------------------
  logic [31:0] rd_word;
  always_comb begin
    rd_word = `PSS_RST_WORD;
    if (idx == `PSS_IDX_SUMMARY)
      rd_word[15:0] = summary;
    else if (idx == `PSS_IDX_IRQ_STATUS)
      rd_word[`PSS_EV_W-1:0] = irq_status;
    else if (idx == `PSS_IDX_IRQ_MASK)
      rd_word[`PSS_EV_W-1:0] = irq_mask;
    else if (idx == `PSS_IDX_XOVER_CTRL)
      rd_word[`PSS_XC_W-1:0] = xover_ctrl;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state   <= PSS_IDLE;
      prdata  <= `PSS_RST_WORD;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      case (state)
        PSS_IDLE: begin
          pready  <= 1'b0;
          pslverr <= 1'b0;
          if (setup) begin
            state   <= PSS_ACCESS;
            pready  <= 1'b1;
            pslverr <= bad;
            prdata  <= (pwrite || bad) ? `PSS_RST_WORD : rd_word;
          end
        end
        PSS_ACCESS: begin
          state   <= PSS_IDLE;
          pready  <= 1'b0;
          pslverr <= 1'b0;
        end
        default: state <= PSS_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  property p_top_zero;
    @(posedge clk) disable iff (!reset_n)
      (pready && !pwrite && (idx == `PSS_IDX_SUMMARY)) |-> !prdata[15];
  endproperty
  a_top_zero: assert property (p_top_zero)
    else $error("summary top bit read as one");

  property p_force_swap;
    @(posedge clk) disable iff (!reset_n)
      xover_ctrl[`PSS_XC_FORCE] |-> summary[`PSS_BIT_XOVER];
  endproperty
  a_force_swap: assert property (p_force_swap)
    else $error("forced crossover not shown");

  property p_rxerr_set;
    @(posedge clk) disable iff (!reset_n)
      sync_b.rx_error |=> rxerr_latch;
  endproperty
  a_rxerr_set: assert property (p_rxerr_set)
    else $error("receive error latch not set");

  property p_rxerr_hold;
    @(posedge clk) disable iff (!reset_n)
      (rxerr_latch && !rd_rxcnt) |=> rxerr_latch;
  endproperty
  a_rxerr_hold: assert property (p_rxerr_hold)
    else $error("receive error latch lost without counter read");

  property p_rxerr_clear;
    @(posedge clk) disable iff (!reset_n)
      (rd_rxcnt && !sync_b.rx_error) |=> !rxerr_latch;
  endproperty
  a_rxerr_clear: assert property (p_rxerr_clear)
    else $error("receive error latch not cleared by counter read");

  property p_pol_keep;
    @(posedge clk) disable iff (!reset_n)
      (pol_flag && !rd_tenmeg) |=> pol_flag;
  endproperty
  a_pol_keep: assert property (p_pol_keep)
    else $error("polarity flag lost without ten-meg read");

  property p_fcar_clear;
    @(posedge clk) disable iff (!reset_n)
      (rd_fccr && !sync_b.false_carrier) |=> !fcar_latch;
  endproperty
  a_fcar_clear: assert property (p_fcar_clear)
    else $error("false carrier latch not cleared");

  property p_sig_low;
    @(posedge clk) disable iff (!reset_n)
      (!sync_b.signal_detect && !rd_summary) |=> !sigdet_ll;
  endproperty
  a_sig_low: assert property (p_sig_low)
    else $error("signal detect did not latch low");

  property p_lock_low;
    @(posedge clk) disable iff (!reset_n)
      (!lock_ll && !rd_summary) |=> !lock_ll;
  endproperty
  a_lock_low: assert property (p_lock_low)
    else $error("descrambler lock low not held");

  property p_rf_set_wins;
    @(posedge clk) disable iff (!reset_n)
      (rd_basic && sync_b.partner_remote_fault) |=> rfault_flag;
  endproperty
  a_rf_set_wins: assert property (p_rf_set_wins)
    else $error("remote fault lost in clearing cycle");

  property p_rf_clear;
    @(posedge clk) disable iff (!reset_n)
      (rd_basic && !sync_b.partner_remote_fault) |=> !rfault_flag;
  endproperty
  a_rf_clear: assert property (p_rf_clear)
    else $error("remote fault not cleared by basic status read");

  property p_xover_normal;
    @(posedge clk) disable iff (!reset_n)
      (!xover_ctrl[`PSS_XC_FORCE] && !xover_ctrl[`PSS_XC_ENABLE])
        |-> !summary[`PSS_BIT_XOVER];
  endproperty
  a_xover_normal: assert property (p_xover_normal)
    else $error("crossover shown while disabled");

  property p_pol_set;
    @(posedge clk) disable iff (!reset_n)
      sync_b.polarity_inverted |=> pol_flag;
  endproperty
  a_pol_set: assert property (p_pol_set)
    else $error("polarity flag not set");

  property p_page_keep;
    @(posedge clk) disable iff (!reset_n)
      (page_flag && !rd_expand) |=> page_flag;
  endproperty
  a_page_keep: assert property (p_page_keep)
    else $error("page flag lost without expansion read");

  property p_irq_out;
    @(posedge clk) disable iff (!reset_n)
      |(irq_status & irq_mask) |-> irq;
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("interrupt output low with unmasked status");

endmodule : pss_status_summary
`default_nettype wire

// ==== verification/pss_status_summary_test.sv ====
// Self-checking bench for the status summary block
`timescale 1ns/1ps
`default_nettype none
`include "pss_params.svh"

module pss_status_summary_test
  import pss_pkg::*;
;
  // ---------------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------------
  logic             clk;
  logic             reset_n;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [11:0]      paddr;
  logic [31:0]      pwdata;
  pss_phy_in_type   phy_in;
  wire logic [31:0] prdata;
  wire logic        pready;
  wire logic        pslverr;
  wire logic        irq;
  logic [31:0]      rdat;
  logic             rerr;
  int               err_count;
  int               n_checks;

  localparam logic [11:0] a_sum = {4'h0, `PSS_IDX_SUMMARY, 2'b00};
  localparam logic [11:0] a_xc  = {4'h0, `PSS_IDX_XOVER_CTRL, 2'b00};
  localparam logic [11:0] a_ist = {4'h0, `PSS_IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] a_imk = {4'h0, `PSS_IDX_IRQ_MASK, 2'b00};
  localparam logic [31:0] xb    = 32'h1 << `PSS_BIT_XOVER;
  localparam logic [31:0] ll    = (32'h1 << `PSS_BIT_SIGDET) |
                                  (32'h1 << `PSS_BIT_LOCK);

  pss_status_summary DUT (
    .clk     (clk),
    .reset_n (reset_n),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .phy_in  (phy_in),
    .irq     (irq)
  );

  always #50 clk = ~clk;

  // ---------------------------------------------------------------------
  // Bus and comparison tasks
  // ---------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Holds the request until pready is seen high; the watchdog covers
  // a slave that never answers
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rdat, exp);
  endtask : rchk

  // Pulse a source, see it stick through summary reads, clear it by its
  // own register, then hold the source across the clearing read
  task automatic sticky(input int src, input int b, input logic [5:0] ci);
    logic [11:0] ca;
    ca = {4'h0, ci, 2'b00};
    phy_in[src] <= 1'b1;
    cyc(2);
    phy_in[src] <= 1'b0;
    cyc(5);
    rchk(a_sum, 32'h1 << b);
    rchk(a_sum, 32'h1 << b);
    rchk(ca, 32'h0);
    rchk(a_sum, 32'h0);
    phy_in[src] <= 1'b1;
    cyc(5);
    rchk(ca, 32'h0);
    rchk(a_sum, 32'h1 << b);
    phy_in[src] <= 1'b0;
    cyc(5);
    rchk(ca, 32'h0);
    rchk(a_sum, 32'h0);
    $display("test sticky bit %0d done", b);
  endtask : sticky

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  // ---------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------
  initial begin
    clk       = 1'b0;
    reset_n   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0;
    phy_in    = '0;
    err_count = 0;
    n_checks  = 0;
    cyc(8);
    reset_n <= 1'b1;
    rchk(a_sum, 32'h0);
    wr(a_sum, 32'hFFFF_FFFF);
    check({31'h0, rerr}, 32'h0);
    rchk(a_sum, 32'h0);
    $display("test reset and write-ignore done");
    phy_in.auto_swapped <= 1'b1;
    cyc(5);
    rchk(a_sum, xb);
    wr(a_xc, 32'h0);
    rchk(a_sum, 32'h0);
    phy_in.auto_swapped <= 1'b0;
    wr(a_xc, 32'h3);
    rchk(a_sum, xb);
    wr(a_xc, 32'h2);
    rchk(a_sum, xb);
    wr(a_xc, 32'h1);
    rchk(a_sum, 32'h0);
    $display("test crossover done");
    sticky(7, `PSS_BIT_RXERR, `PSS_IDX_RXERR_CNT);
    sticky(6, `PSS_BIT_POL, `PSS_IDX_TENMEG);
    sticky(5, `PSS_BIT_FCAR, `PSS_IDX_FCCR);
    sticky(2, `PSS_BIT_PAGE, `PSS_IDX_AN_EXPAND);
    sticky(1, `PSS_BIT_IRQ, `PSS_IDX_ISER);
    sticky(0, `PSS_BIT_RFAULT, `PSS_IDX_BASIC_STAT);
    phy_in[4] <= 1'b1;
    phy_in[3] <= 1'b1;
    cyc(5);
    xfer(1'b0, a_sum, 32'h0);
    rchk(a_sum, ll);
    phy_in[4] <= 1'b0;
    phy_in[3] <= 1'b0;
    cyc(2);
    phy_in[4] <= 1'b1;
    phy_in[3] <= 1'b1;
    cyc(5);
    rchk(a_sum, 32'h0);
    rchk(a_sum, ll);
    phy_in[4] <= 1'b0;
    phy_in[3] <= 1'b0;
    cyc(5);
    xfer(1'b0, a_sum, 32'h0);
    rchk(a_sum, 32'h0);
    $display("test latch-low done");
    // Three event kinds were raised above, all still pending but masked
    rchk(a_ist, 32'h7);
    check({31'h0, irq}, 32'h0);
    wr(a_imk, 32'h2);
    cyc(2);
    check({31'h0, irq}, 32'h1);
    wr(a_ist, 32'h2);
    cyc(2);
    check({31'h0, irq}, 32'h0);
    rchk(a_ist, 32'h5);
    wr(a_imk, 32'h7);
    cyc(2);
    check({31'h0, irq}, 32'h1);
    wr(a_ist, 32'h7);
    cyc(2);
    check({31'h0, irq}, 32'h0);
    rchk(a_ist, 32'h0);
    $display("test interrupt done");
    rchk(12'h3FC, 32'h0);
    check({31'h0, rerr}, 32'h1);
    rchk(12'h0C0, 32'h0);
    check({31'h0, rerr}, 32'h1);
    rchk(12'h042, 32'h0);
    check({31'h0, rerr}, 32'h1);
    $display("test refusal done");
    phy_in.partner_remote_fault <= 1'b1;
    cyc(3);
    phy_in.partner_remote_fault <= 1'b0;
    cyc(5);
    rchk(a_sum, 32'h1 << `PSS_BIT_RFAULT);
    reset_n <= 1'b0;
    cyc(8);
    reset_n <= 1'b1;
    rchk(a_sum, 32'h0);
    $display("test fault reset done");
    close_out();
  end

  // Whole sequence takes well under two thousand cycles
  initial begin
    #(100 * 20000);
    err_count++;
    close_out();
  end

endmodule : pss_status_summary_test
`default_nettype wire
